/* File: rtl/tsc_pkg.sv */
package tsc_pkg;
   // register offsets on the configuration port
   localparam logic [7:0] TSC_A_FILTER = 8'h56;
   localparam logic [7:0] TSC_A_SCAN0 = 8'h5C;
   localparam logic [7:0] TSC_A_SCAN1 = 8'h5D;
   localparam logic [7:0] TSC_A_THR0 = 8'h66;
   localparam logic [7:0] TSC_A_THR1 = 8'h67;
   localparam logic [7:0] TSC_A_CUR0 = 8'h70;
   localparam logic [7:0] TSC_A_CUR1 = 8'h71;
   localparam logic [7:0] TSC_A_GUARD = 8'h79;
   localparam logic [7:0] TSC_A_PRODID = 8'h7A;
   localparam logic [7:0] TSC_A_SLVADR = 8'h7C;
   // registers that must be set before per-sensor tuning
   localparam logic [7:0] TSC_A_PRE0 = 8'h07;
   localparam logic [7:0] TSC_A_PRE1 = 8'h50;
   localparam logic [7:0] TSC_A_PRE2 = 8'h51;
   // filter control fields
   localparam int TSC_B_BLRST = 7;
   localparam int TSC_B_DROP = 5;
   localparam int TSC_B_AVGEN = 4;
   localparam int TSC_B_ORD_LO = 0;
   localparam int TSC_B_ORD_HI = 1;
   // address and guard register fields
   localparam int TSC_B_PULLUP = 7;
   localparam int TSC_B_LOCK = 0;
   // reset values
   localparam logic TSC_R_DROP = 1'b1;
   localparam logic TSC_R_AVGEN = 1'b0;
   localparam logic [1:0] TSC_R_ORDER = 2'h0;
   localparam logic TSC_R_SCAN = 1'b0;
   localparam logic [7:0] TSC_R_THR = 8'h64;
   localparam logic [7:0] TSC_R_CUR = 8'h0A;
   localparam logic TSC_R_LOCK = 1'b0;
   localparam logic [7:0] TSC_R_SLVADR = 8'h00;
   // host-side value limits
   localparam logic [7:0] TSC_THR_MIN = 8'h03;
   localparam logic [7:0] TSC_CUR_NOISY = 8'h04;
   // guard byte sequences
   localparam logic [7:0] TSC_UNL0 = 8'h3C;
   localparam logic [7:0] TSC_UNL1 = 8'hA5;
   localparam logic [7:0] TSC_UNL2 = 8'h69;
   localparam logic [7:0] TSC_LCK0 = 8'h96;
   localparam logic [7:0] TSC_LCK1 = 8'h5A;
   localparam logic [7:0] TSC_LCK2 = 8'hC3;
   // guard sequence detector states
   typedef enum logic [4:0] {
      TSC_G_IDLE = 5'b00001,
      TSC_G_U1 = 5'b00010,
      TSC_G_U2 = 5'b00100,
      TSC_G_L1 = 5'b01000,
      TSC_G_L2 = 5'b10000
   } tsc_guard_e;
   // host engine states
   typedef enum logic [1:0] {
      TSC_H_IDLE = 2'b01,
      TSC_H_WAIT = 2'b10
   } tsc_host_e;
endpackage

/* File: rtl/tsc_if.sv */
`timescale 1ns/10ps
`default_nettype none
// register channel between the configuration host and the device
interface tsc_if;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport dev (input req, input we, input addr, input wdata,
                output ack, output rdata);
   modport host (output req, output we, output addr, output wdata,
                 input ack, input rdata);
endinterface
`default_nettype wire

/* File: rtl/tsc_lock_seq.sv */
`timescale 1ns/10ps
`default_nettype none
module tsc_lock_seq
   import tsc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // writes aimed at the guard register
   input wire logic wr_stb,
   input wire logic [7:0] wr_byte,
   // sequence completed in this write
   output logic unlock_hit,
   output logic lock_hit
);
   tsc_guard_e st_q;
   tsc_guard_e st_d;

   // a wrong byte restarts, but may itself open a new sequence
   wire logic is_u0 = (wr_byte == TSC_UNL0);
   wire logic is_l0 = (wr_byte == TSC_LCK0);
   wire tsc_guard_e restart = is_u0 ? TSC_G_U1 :
                              (is_l0 ? TSC_G_L1 : TSC_G_IDLE);

   always_comb begin
      st_d = st_q;
      unlock_hit = 1'b0;
      lock_hit = 1'b0;
      if (wr_stb) begin
         unique case (st_q)
            TSC_G_U1: st_d = (wr_byte == TSC_UNL1) ? TSC_G_U2 : restart;
            TSC_G_U2: begin
               unlock_hit = (wr_byte == TSC_UNL2);
               st_d = unlock_hit ? TSC_G_IDLE : restart;
            end
            TSC_G_L1: st_d = (wr_byte == TSC_LCK1) ? TSC_G_L2 : restart;
            TSC_G_L2: begin
               lock_hit = (wr_byte == TSC_LCK2);
               st_d = lock_hit ? TSC_G_IDLE : restart;
            end
            TSC_G_IDLE: st_d = restart;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst)
         st_q <= TSC_G_IDLE;
      else
         st_q <= st_d;
   end
endmodule
`default_nettype wire

/* File: rtl/tsc_dev_end.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - baseline reset bit pulses, then self-clears
// - drop scan samples overlapping bus traffic
// - average enable bit switches raw averaging
// - depth code selects 2, 4, 8, 16
// - bit 0 sets sensor scan order
// - scan order writable only in setup
// - single-button variant lacks sensor-1 registers
// - host tunes after 07h, 50h, 51h
// - host keeps thresholds within 3..255
// - per-sensor 8-bit threshold, resets to 64h
// - current level zero becomes default ten
// - host avoids current levels four or below
// - 3Ch A5h 69h unlocks address register
// - 96h 5Ah C3h relocks address register
// - address writes ignored while locked
// - new address applies only on relock
// - guard read returns lock state bit 0
// - read-only product identifier per variant
// - address bits 6:0, pull-up disable bit 7
module tsc_dev_end
   import tsc_pkg::*;
#(
   parameter bit TWO_BUTTON = 1'b1,
   parameter logic [7:0] PRODUCT_ID = 8'hA7, // arbitrary value
   parameter int SAMPLE_W = 16
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // register channel
   tsc_if.dev bus,
   // sensing core status
   input wire logic setup_mode,
   input wire logic scan_busy,
   input wire logic sample_in_valid,
   input wire logic [SAMPLE_W-1:0] sample_in,
   // filter controls to the sensing core
   output logic baseline_force_reset,
   output logic bus_busy_sample_drop,
   output logic average_enable,
   output logic [4:0] average_samples,
   output logic sample_out_valid,
   output logic [SAMPLE_W-1:0] sample_out,
   // per-sensor settings
   output logic [1:0] scan_order,
   output logic [15:0] touch_threshold,
   output logic [15:0] sense_current_level,
   // bus address in effect
   output logic [6:0] slave_address,
   output logic pullup_disable,
   output logic address_lock_state
);
   localparam int NSENS = TWO_BUTTON ? 2 : 1;

   // refuse a sample width that the sample path cannot carry
   if (SAMPLE_W < 1) begin : g_bad_width
      $error("sample width must be positive");
   end

   logic ack_q;
   logic [7:0] rdata_q;
   logic blrst_q;
   logic drop_q;
   logic avgen_q;
   logic [1:0] order_q;
   logic [4:0] avgn_q;
   logic [1:0] scan_q;
   logic [7:0] thr_q [2];
   logic [7:0] cur_q [2];
   logic lock_q;
   logic [7:0] staged_q;
   logic [7:0] applied_q;
   logic traffic_q;
   logic sov_q;
   logic [SAMPLE_W-1:0] so_q;

   // write strobes per register
   wire logic wr = bus.req & bus.we;
   wire logic wr_filt = wr & (bus.addr == TSC_A_FILTER);
   wire logic wr_guard = wr & (bus.addr == TSC_A_GUARD);
   wire logic wr_slv = wr & (bus.addr == TSC_A_SLVADR);
   wire logic [7:0] slot_a [2];
   wire logic [7:0] thr_a [2];
   wire logic [7:0] cur_a [2];
   assign slot_a[0] = TSC_A_SCAN0;
   assign slot_a[1] = TSC_A_SCAN1;
   assign thr_a[0] = TSC_A_THR0;
   assign thr_a[1] = TSC_A_THR1;
   assign cur_a[0] = TSC_A_CUR0;
   assign cur_a[1] = TSC_A_CUR1;

   wire logic unlock_hit;
   wire logic lock_hit;

   tsc_lock_seq u_lock (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .wr_stb(wr_guard),
      .wr_byte(bus.wdata),
      .unlock_hit(unlock_hit),
      .lock_hit(lock_hit)
   );

   // per-sensor registers; the second one only in the two-button build
   logic [7:0] sens_rd [2];
   logic [1:0] sens_hit;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sens
         if (g < NSENS) begin : g_on
            wire logic w_slot = wr & (bus.addr == slot_a[g]);
            wire logic w_thr = wr & (bus.addr == thr_a[g]);
            wire logic w_cur = wr & (bus.addr == cur_a[g]);
            // scan order only moves in setup mode
            always_ff @(posedge ref_clk) begin
               if (!nrst)
                  scan_q[g] <= TSC_R_SCAN;
               else if (w_slot && setup_mode)
                  scan_q[g] <= bus.wdata[0];
            end
            always_ff @(posedge ref_clk) begin
               if (!nrst)
                  thr_q[g] <= TSC_R_THR;
               else if (w_thr)
                  thr_q[g] <= bus.wdata;
            end
            // zero would stall the sensing current, so fall back to default
            always_ff @(posedge ref_clk) begin
               if (!nrst)
                  cur_q[g] <= TSC_R_CUR;
               else if (w_cur)
                  cur_q[g] <= (bus.wdata == 8'h00) ? TSC_R_CUR : bus.wdata;
            end
            assign sens_hit[g] = (bus.addr == slot_a[g]) |
                                 (bus.addr == thr_a[g]) |
                                 (bus.addr == cur_a[g]);
            assign sens_rd[g] = (bus.addr == slot_a[g]) ? {7'h00, scan_q[g]} :
                                (bus.addr == thr_a[g]) ? thr_q[g] :
                                cur_q[g];
         end else begin : g_off
            // absent sensor: unmapped, reads zero, settings parked
            always_ff @(posedge ref_clk) begin
               scan_q[g] <= TSC_R_SCAN;
               thr_q[g] <= TSC_R_THR;
               cur_q[g] <= TSC_R_CUR;
            end
            assign sens_hit[g] = 1'b0;
            assign sens_rd[g] = 8'h00;
         end
      end
   endgenerate

   // filter control; baseline reset is a one-cycle pulse and reads back 0
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         blrst_q <= 1'b0;
         drop_q <= TSC_R_DROP;
         avgen_q <= TSC_R_AVGEN;
         order_q <= TSC_R_ORDER;
      end else begin
         blrst_q <= wr_filt & bus.wdata[TSC_B_BLRST];
         if (wr_filt) begin
            drop_q <= bus.wdata[TSC_B_DROP];
            avgen_q <= bus.wdata[TSC_B_AVGEN];
            order_q <= bus.wdata[TSC_B_ORD_HI:TSC_B_ORD_LO];
         end
      end
   end

   // depth code n means 2 << n samples
   always_ff @(posedge ref_clk) begin
      if (!nrst)
         avgn_q <= 5'h02;
      else
         avgn_q <= 5'h02 << order_q;
   end

   // guard lock and the staged/applied slave address
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         lock_q <= TSC_R_LOCK;
         staged_q <= TSC_R_SLVADR;
         applied_q <= TSC_R_SLVADR;
      end else begin
         if (unlock_hit)
            lock_q <= 1'b0;
         else if (lock_hit) begin
            lock_q <= 1'b1;
            applied_q <= staged_q;
         end
         if (wr_slv && !lock_q)
            staged_q <= bus.wdata;
      end
   end

   // a sample is dropped, while drop is on, if any bus request fell inside its scan
   wire logic drop_now = drop_q & (traffic_q | bus.req);
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         traffic_q <= 1'b0;
         sov_q <= 1'b0;
         so_q <= '0;
      end else begin
         if (sample_in_valid)
            traffic_q <= 1'b0;
         else if (scan_busy && bus.req)
            traffic_q <= 1'b1;
         sov_q <= sample_in_valid & ~drop_now;
         if (sample_in_valid)
            so_q <= sample_in;
      end
   end

   // read selection; unmapped offsets read zero
   wire logic [7:0] filt_rd = {1'b0, 1'b0, drop_q, avgen_q, 2'h0, order_q};
   wire logic [7:0] rd_mux =
      (bus.addr == TSC_A_FILTER) ? filt_rd :
      sens_hit[0] ? sens_rd[0] :
      sens_hit[1] ? sens_rd[1] :
      (bus.addr == TSC_A_GUARD) ? {7'h00, lock_q} :
      (bus.addr == TSC_A_PRODID) ? PRODUCT_ID :
      (bus.addr == TSC_A_SLVADR) ? staged_q : 8'h00;

   // every request is answered one cycle later
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= bus.req;
         rdata_q <= (bus.req && !bus.we) ? rd_mux : 8'h00;
      end
   end

   assign bus.ack = ack_q;
   assign bus.rdata = rdata_q;
   assign baseline_force_reset = blrst_q;
   assign bus_busy_sample_drop = drop_q;
   assign average_enable = avgen_q;
   assign average_samples = avgn_q;
   assign sample_out_valid = sov_q;
   assign sample_out = so_q;
   assign scan_order = scan_q;
   assign touch_threshold = {thr_q[1], thr_q[0]};
   assign sense_current_level = {cur_q[1], cur_q[0]};
   assign slave_address = applied_q[6:0];
   assign pullup_disable = applied_q[TSC_B_PULLUP];
   assign address_lock_state = lock_q;
endmodule
`default_nettype wire

/* File: rtl/tsc_host_end.sv */
`timescale 1ns/10ps
`default_nettype none
module tsc_host_end
   import tsc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // register channel
   tsc_if.host bus,
   // user commands
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic cmd_ready,
   output logic cmd_refused,
   // guard sequence requests
   input wire logic unlock_go,
   input wire logic lock_go,
   // answers
   output logic rsp_valid,
   output logic [7:0] rsp_rdata
);
   tsc_host_e st_q;
   logic req_q;
   logic we_q;
   logic [7:0] addr_q;
   logic [7:0] wdata_q;
   logic rdy_q;
   logic ref_q;
   logic rv_q;
   logic [7:0] rd_q;
   logic [2:0] pre_q;
   logic seq_q;
   logic seq_lock_q;
   logic [1:0] seq_idx_q;

   // tuning registers and the prerequisites they wait on
   wire logic is_thr = (cmd_addr == TSC_A_THR0) | (cmd_addr == TSC_A_THR1);
   wire logic is_cur = (cmd_addr == TSC_A_CUR0) | (cmd_addr == TSC_A_CUR1);
   wire logic is_tune = is_thr | is_cur | (cmd_addr == TSC_A_SCAN0) |
                        (cmd_addr == TSC_A_SCAN1);
   wire logic bad = cmd_write & ((is_tune & ~&pre_q) |
                    (is_thr & (cmd_wdata < TSC_THR_MIN)) |
                    (is_cur & (cmd_wdata <= TSC_CUR_NOISY)));
   wire logic [7:0] seq_byte =
      seq_lock_q ? ((seq_idx_q == 2'h0) ? TSC_LCK0 :
                    (seq_idx_q == 2'h1) ? TSC_LCK1 : TSC_LCK2) :
                   ((seq_idx_q == 2'h0) ? TSC_UNL0 :
                    (seq_idx_q == 2'h1) ? TSC_UNL1 : TSC_UNL2);
   wire logic idle = (st_q == TSC_H_IDLE);
   wire logic take_cmd = idle & ~seq_q & cmd_valid & rdy_q;

   // one request outstanding; guard bytes go back to back before user work
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_q <= TSC_H_IDLE;
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         seq_q <= 1'b0;
         seq_lock_q <= 1'b0;
         seq_idx_q <= 2'h0;
      end else begin
         req_q <= 1'b0;
         unique case (st_q)
            TSC_H_IDLE: begin
               if (seq_q) begin
                  req_q <= 1'b1;
                  we_q <= 1'b1;
                  addr_q <= TSC_A_GUARD;
                  wdata_q <= seq_byte;
                  st_q <= TSC_H_WAIT;
               end else if (unlock_go || lock_go) begin
                  seq_q <= 1'b1;
                  seq_lock_q <= lock_go & ~unlock_go;
                  seq_idx_q <= 2'h0;
               end else if (take_cmd && !bad) begin
                  req_q <= 1'b1;
                  we_q <= cmd_write;
                  addr_q <= cmd_addr;
                  wdata_q <= cmd_wdata;
                  st_q <= TSC_H_WAIT;
               end
            end
            TSC_H_WAIT: begin
               if (bus.ack) begin
                  st_q <= TSC_H_IDLE;
                  if (seq_q) begin
                     seq_idx_q <= seq_idx_q + 2'h1;
                     seq_q <= (seq_idx_q != 2'h2);
                  end
               end
            end
         endcase
      end
   end

   // user handshake, answers and prerequisite tracking
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdy_q <= 1'b0;
         ref_q <= 1'b0;
         rv_q <= 1'b0;
         rd_q <= 8'h00;
         pre_q <= 3'h0;
      end else begin
         rdy_q <= idle & ~seq_q & ~take_cmd & ~unlock_go & ~lock_go;
         ref_q <= take_cmd & bad;
         rv_q <= bus.ack & ~seq_q & (st_q == TSC_H_WAIT);
         if (bus.ack)
            rd_q <= bus.rdata;
         if (take_cmd && cmd_write) begin
            pre_q[0] <= pre_q[0] | (cmd_addr == TSC_A_PRE0);
            pre_q[1] <= pre_q[1] | (cmd_addr == TSC_A_PRE1);
            pre_q[2] <= pre_q[2] | (cmd_addr == TSC_A_PRE2);
         end
      end
   end

   assign bus.req = req_q;
   assign bus.we = we_q;
   assign bus.addr = addr_q;
   assign bus.wdata = wdata_q;
   assign cmd_ready = rdy_q;
   assign cmd_refused = ref_q;
   assign rsp_valid = rv_q;
   assign rsp_rdata = rd_q;
endmodule
`default_nettype wire

/* File: dv/tsc_link_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module tsc_link_properties
   import tsc_pkg::*;
#(
   parameter logic [7:0] PRODUCT_ID = 8'hA7 // arbitrary value
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // register channel
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // one read request at a given offset
   sequence rd_at(logic [7:0] a);
      req && !we && addr == a;
   endsequence
   // one guard write carrying a given byte
   sequence gw(logic [7:0] b);
      req && we && addr == TSC_A_GUARD && wdata == b;
   endsequence
   // guard bytes back to back; only one request fits in each gap
   sequence unlock_run;
      gw(TSC_UNL0) ##[1:4] gw(TSC_UNL1) ##[1:4] gw(TSC_UNL2);
   endsequence
   sequence lock_run;
      gw(TSC_LCK0) ##[1:4] gw(TSC_LCK1) ##[1:4] gw(TSC_LCK2);
   endsequence
   // channel timing
   ack_after_req_a: assert property (req |=> ack)
      else $error("no ack one cycle after request");
   ack_quiet_a: assert property (!req |=> !ack)
      else $error("ack without request");
   req_spacing_a: assert property (req |=> !req [*2])
      else $error("requests closer than three cycles");
   write_ack_zero_a: assert property (req && we |=> rdata == 8'h00)
      else $error("write ack carries data");
   unmapped_zero_a: assert property (rd_at(8'h00) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   // register contents seen on reads
   product_id_a: assert property (rd_at(TSC_A_PRODID) |=> rdata == PRODUCT_ID)
      else $error("product identifier wrong");
   guard_bits_a: assert property (rd_at(TSC_A_GUARD) |=> rdata[7:1] == 7'h00)
      else $error("guard read upper bits set");
   baseline_clear_a: assert property (rd_at(TSC_A_FILTER) |=> !rdata[TSC_B_BLRST])
      else $error("baseline reset bit reads one");
   // zero is never stored as a current level, it falls back to default
   current_floor_a: assert property (rd_at(TSC_A_CUR0) |=> rdata != 8'h00)
      else $error("current level reads zero");
   unlock_read_a: assert property (unlock_run ##[1:20] rd_at(TSC_A_GUARD) |=> !rdata[TSC_B_LOCK])
      else $error("guard still locked after unlock bytes");
   lock_read_a: assert property (lock_run ##[1:20] rd_at(TSC_A_GUARD) |=> rdata[TSC_B_LOCK])
      else $error("guard not locked after lock bytes");
endmodule
`default_nettype wire

/* File: dv/touch_sense_config_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module touch_sense_config_regs_tb;
   import tsc_pkg::*;
   localparam logic [7:0] PID = 8'hA7; // arbitrary value
   localparam logic N = 1'b0;
   localparam logic Y = 1'b1;
   // one user command and the answer it should give
   typedef struct packed {
      logic w;
      logic s;
      logic [7:0] a;
      logic [7:0] d;
      logic rf;
      logic [7:0] rd;
   } tsc_row_s;
   tsc_row_s rows [0:25] = '{
      '{N,N,TSC_A_THR0,8'h00,N,8'h64}, '{N,N,TSC_A_THR1,8'h00,N,8'h64},
      '{N,N,TSC_A_CUR0,8'h00,N,8'h0A}, '{N,N,TSC_A_CUR1,8'h00,N,8'h0A},
      '{N,N,TSC_A_FILTER,8'h00,N,8'h20}, '{N,N,TSC_A_GUARD,8'h00,N,8'h00},
      '{N,N,TSC_A_PRODID,8'h00,N,PID}, '{N,N,8'h00,8'h00,N,8'h00},
      '{Y,N,TSC_A_THR0,8'h40,Y,8'h00}, '{Y,N,TSC_A_PRE0,8'h01,N,8'h00},
      '{Y,N,TSC_A_PRE1,8'h02,N,8'h00}, '{Y,N,TSC_A_PRE2,8'h03,N,8'h00},
      '{Y,N,TSC_A_THR0,8'h02,Y,8'h00}, '{Y,N,TSC_A_THR0,8'h03,N,8'h00},
      '{N,N,TSC_A_THR0,8'h00,N,8'h03}, '{Y,N,TSC_A_THR1,8'hFF,N,8'h00},
      '{N,N,TSC_A_THR1,8'h00,N,8'hFF}, '{Y,N,TSC_A_CUR0,8'h04,Y,8'h00},
      '{Y,N,TSC_A_CUR1,8'h05,N,8'h00}, '{N,N,TSC_A_CUR1,8'h00,N,8'h05},
      '{Y,N,TSC_A_SCAN0,8'h01,N,8'h00}, '{N,N,TSC_A_SCAN0,8'h00,N,8'h00},
      '{Y,Y,TSC_A_SCAN0,8'h01,N,8'h00}, '{N,N,TSC_A_SCAN0,8'h00,N,8'h01},
      '{Y,Y,TSC_A_SCAN1,8'h01,N,8'h00}, '{N,N,TSC_A_SCAN1,8'h00,N,8'h01}};
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic setup_mode = 1'b0;
   logic scan_busy = 1'b0;
   logic sample_in_valid = 1'b0;
   logic [15:0] sample_in = 16'h0000;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic unlock_go = 1'b0;
   logic lock_go = 1'b0;
   logic cmd_ready, cmd_refused, rsp_valid;
   logic [7:0] rsp_rdata;
   logic baseline_force_reset, bus_busy_sample_drop, average_enable;
   logic [4:0] average_samples;
   logic sample_out_valid;
   logic [15:0] sample_out, touch_threshold, sense_current_level, sv_last;
   logic [1:0] scan_order;
   logic [6:0] slave_address;
   logic pullup_disable, address_lock_state, rf;
   logic [7:0] rd;
   int fails = 0;
   int compares = 0;
   int bl_n = 0;
   int sv_n = 0;
   // 50 MHz clock
   always #10 ref_clk = ~ref_clk;
   tsc_if link ();
   tsc_dev_end #(.TWO_BUTTON(1'b1), .PRODUCT_ID(PID), .SAMPLE_W(16))
   tsc_dev_end_inst (.ref_clk(ref_clk), .nrst(nrst), .bus(link),
      .setup_mode(setup_mode), .scan_busy(scan_busy),
      .sample_in_valid(sample_in_valid), .sample_in(sample_in),
      .baseline_force_reset(baseline_force_reset),
      .bus_busy_sample_drop(bus_busy_sample_drop),
      .average_enable(average_enable), .average_samples(average_samples),
      .sample_out_valid(sample_out_valid), .sample_out(sample_out),
      .scan_order(scan_order), .touch_threshold(touch_threshold),
      .sense_current_level(sense_current_level),
      .slave_address(slave_address), .pullup_disable(pullup_disable),
      .address_lock_state(address_lock_state));
   tsc_host_end tsc_host_end_inst (.ref_clk(ref_clk), .nrst(nrst),
      .bus(link), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .cmd_refused(cmd_refused), .unlock_go(unlock_go), .lock_go(lock_go),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   tsc_link_properties #(.PRODUCT_ID(PID)) tsc_link_properties_inst (
      .ref_clk(ref_clk), .nrst(nrst), .req(link.req), .we(link.we),
      .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
      .rdata(link.rdata));
   // pulse monitors; a pulse is counted on the edge that shows it
   always @(posedge ref_clk) begin
      if (baseline_force_reset === 1'b1) bl_n++;
      if (sample_out_valid === 1'b1) begin
         sv_n++;
         sv_last = sample_out;
      end
   end
   task automatic cmp(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one user command; answer is a refusal or the response byte
   task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_addr = a;
      cmd_wdata = d;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 30) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      rf = 1'b0;
      rd = 8'h00;
      for (n = 0; n < 8; n++) begin
         if (cmd_refused === 1'b1 || rsp_valid === 1'b1) break;
         @(posedge ref_clk);
         #1;
      end
      if (n == 8) fails++;
      rf = cmd_refused;
      if (rsp_valid === 1'b1) rd = rsp_rdata;
   endtask
   // start a guard sequence from idle and wait until it is over
   task automatic guard(input logic lk);
      int n;
      @(negedge ref_clk);
      for (n = 0; n < 30 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
      lock_go = lk;
      unlock_go = !lk;
      @(negedge ref_clk);
      lock_go = 1'b0;
      unlock_go = 1'b0;
      for (n = 0; n < 30 && cmd_ready !== 1'b1; n++) @(negedge ref_clk);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #200000;
      fails++;
      conclude();
   end
   initial begin
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      foreach (rows[i]) begin
         @(negedge ref_clk);
         setup_mode = rows[i].s;
         cmd(rows[i].w, rows[i].a, rows[i].d);
         cmp("row", {7'h00, rows[i].rf, rows[i].rd}, {7'h00, rf, rd});
      end
      @(negedge ref_clk);
      setup_mode = 1'b0;
      cmp("scan order", 16'h0003, {14'h0000, scan_order});
      cmp("thresholds", 16'hFF03, touch_threshold);
      cmp("currents", 16'h050A, sense_current_level);
      $display("table done");
      // every depth code, then a baseline reset with drop back on
      for (int k = 0; k < 4; k++) begin
         cmd(Y, TSC_A_FILTER, 8'h10 | 8'(k));
         cmp("depth", 16'(2 << k), {11'h000, average_samples});
         cmp("avg on", 16'h0001, {15'h0000, average_enable});
         cmp("drop off", 16'h0000, {15'h0000, bus_busy_sample_drop});
      end
      bl_n = 0;
      cmd(Y, TSC_A_FILTER, 8'hA0);
      cmd(N, TSC_A_FILTER, 8'h00);
      cmp("filter read", 16'h0020, {8'h00, rd});
      cmp("baseline pulses", 16'h0001, 16'(bl_n));
      cmp("avg off", 16'h0000, {15'h0000, average_enable});
      $display("filter done");
      // scan with bus traffic is dropped, a quiet scan passes raw
      sv_n = 0;
      for (int k = 0; k < 2; k++) begin
         @(negedge ref_clk);
         scan_busy = 1'b1;
         if (k == 0) cmd(N, TSC_A_PRODID, 8'h00);
         else repeat (5) @(negedge ref_clk);
         @(negedge ref_clk);
         sample_in = 16'h5A5A + 16'(k);
         sample_in_valid = 1'b1;
         @(negedge ref_clk);
         sample_in_valid = 1'b0;
         scan_busy = 1'b0;
         repeat (8) @(negedge ref_clk);
         cmp("samples out", 16'(k), 16'(sv_n));
      end
      cmp("sample value", 16'h5A5B, sv_last);
      $display("drop done");
      // staged address, relock, locked write, broken sequence
      cmd(Y, TSC_A_SLVADR, 8'hA5);
      cmp("address early", 16'h0000, {9'h000, slave_address});
      guard(Y);
      cmp("locked", 16'h0001, {15'h0000, address_lock_state});
      cmp("applied", 16'h00A5, {8'h00, pullup_disable, slave_address});
      cmd(N, TSC_A_GUARD, 8'h00);
      cmp("guard read", 16'h0001, {8'h00, rd});
      cmd(Y, TSC_A_SLVADR, 8'h11);
      cmd(N, TSC_A_SLVADR, 8'h00);
      cmp("address kept", 16'h00A5, {8'h00, rd});
      guard(N);
      cmd(N, TSC_A_GUARD, 8'h00);
      cmp("unlocked", 16'h0000, {8'h00, rd});
      cmd(Y, TSC_A_GUARD, TSC_LCK0);
      cmd(Y, TSC_A_GUARD, TSC_LCK1);
      cmd(Y, TSC_A_GUARD, 8'h00);
      cmd(Y, TSC_A_GUARD, TSC_LCK2);
      cmp("broken run", 16'h0000, {15'h0000, address_lock_state});
      $display("guard done");
      // second reset in mid-run
      @(negedge ref_clk);
      nrst = 1'b0;
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      cmp("reset thr", 16'h6464, touch_threshold);
      cmp("reset depth", 16'h0002, {11'h000, average_samples});
      cmp("reset addr", 16'h0000, {8'h00, pullup_disable, slave_address});
      $display("reset done");
      conclude();
   end
endmodule
`default_nettype wire
